// *** rtl/trs_pkg.sv ***
// ============================================================
// Shared constants for the trap entry and return sequencer
package trs_pkg;
    // ========================================================
    // Register byte offsets on the APB
    localparam logic [7:0] OFF_CFG = 8'h00;    // Configuration
    localparam logic [7:0] OFF_VBASE = 8'h04;  // Vector base
    localparam logic [7:0] OFF_CPS = 8'h08;    // Current status
    localparam logic [7:0] OFF_OPS = 8'h0C;    // Old status
    localparam logic [7:0] OFF_STAT = 8'h10;   // Sequencer state
    localparam logic [7:0] OFF_HADDR = 8'h14;  // Last handler address
    // ========================================================
    // Field positions
    localparam int CFG_VTM_BIT = 0;      // vector_table_mode
    localparam int CFG_RV_BIT = 1;       // rom_vector_area
    localparam int CPS_FZ_BIT = 10;      // freeze_bit
    localparam int CPS_RE_BIT = 8;       // handler_in_rom
    localparam int VEC_ROM_BIT = 0;      // ROM select in a vector word
    localparam int VE_LO = 2;            // Vector number in table addr
    localparam int BLK_LO = 8;           // Vector number in block addr
    localparam int VEC_W = 8;            // Vector number width
    localparam int STAT_BUSY_BIT = 0;    // Entry in progress
    localparam int STAT_VTM_BIT = 1;     // Mode used by last entry
    localparam int STAT_VEC_LO = 8;      // Last vector number
    // ========================================================
    // Reset values and access codes
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] VBASE_RST = 32'h0000_0000;
    localparam logic [31:0] CPS_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_ALIGN = 32'hFFFF_FFFC;
    localparam logic [2:0] OPT_WORD = 3'h0;  // Full word length
    // Entry status value and the bits it affects
    localparam logic [31:0] CPS_ENTRY_SET = 32'h0000_0000;
    localparam logic [31:0] CPS_ENTRY_MASK = 32'h0000_0000;
endpackage

// *** rtl/trs_addr.sv ***
`timescale 1ns/100ps
// ============================================================
// Handler address forming
module trs_addr (
    // Sources
    input wire logic [31:0] i_base,
    input wire logic [7:0] i_vec,
    input wire logic [31:0] i_vec_word,
    // Results
    output logic [31:0] o_table_addr,
    output logic [31:0] o_block_addr,
    output logic [31:0] o_vec_target,
    output logic o_vec_rom
);
    // Replace an eight-bit field at a given low bit
    function automatic logic [31:0] put_vec(input logic [31:0] b,
            input logic [7:0] v, input int lo);
        logic [31:0] m;
        m = 32'h0000_00FF << lo;
        put_vec = (b & ~m) | ((32'(v) << lo) & m);
    endfunction

    // Table entry and block start addresses
    assign o_table_addr = put_vec(i_base, i_vec, trs_pkg::VE_LO); // RULE_20
    assign o_block_addr = put_vec(i_base, i_vec, trs_pkg::BLK_LO); // RULE_21
    // Word address and ROM select out of the fetched vector
    assign o_vec_target = i_vec_word & trs_pkg::WORD_ALIGN;
    assign o_vec_rom = i_vec_word[trs_pkg::VEC_ROM_BIT]; // RULE_22
endmodule

// *** rtl/trs_seq.sv ***
`timescale 1ns/100ps
// ============================================================
// What this block does
// RULE_01: Stop executing instructions first on entry
// RULE_02: Then stop fetching instructions
// RULE_03: Let an ongoing load or store finish
// RULE_04: Multiple transfer: finish current, cancel rest
// RULE_05: Copy status to old status, then update
// RULE_06: Freeze bit holds channel, counters, ALU status
// RULE_07: Table mode reads handler vector from memory
// RULE_08: Vector read is word-length data access
// RULE_09: Block mode forms address without memory read
// RULE_10: Table mode copies vector ROM bit
// RULE_11: Block mode copies ROM vector-area bit
// RULE_12: Fetch handler address, then resume execution
// RULE_13: Save no other registers on entry
// RULE_14: Handler software saves registers it needs
// RULE_15: Software clears freeze two instructions early
// RULE_16: Return with invalidate clears branch cache
// RULE_17: Plain return leaves branch cache alone
// RULE_18: Software sets freeze before a return
// RULE_19: Entry takes an eight-bit vector number
// RULE_20: Table address replaces base bits nine to two
// RULE_21: Block address replaces base bits fifteen to eight
// RULE_22: Vector ROM bit: zero memory, one ROM
// RULE_23: Entry status value is a parameter
module trs_seq #(
    parameter logic [31:0] ENTRY_SET = trs_pkg::CPS_ENTRY_SET,
    parameter logic [31:0] ENTRY_MASK = trs_pkg::CPS_ENTRY_MASK
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Core trap and return requests
    input wire logic i_trap_req,
    input wire logic [7:0] i_trap_vec,
    input wire logic i_ret_req,
    input wire logic i_ret_inv,
    // Core load/store state
    input wire logic i_ls_busy,
    input wire logic i_lsm_active,
    // Core control
    output logic o_exec_hold,
    output logic o_fetch_hold,
    output logic o_lsm_cancel,
    output logic o_freeze,
    output logic o_fetch_start,
    output logic [31:0] o_fetch_addr,
    output logic o_fetch_rom,
    output logic o_resume,
    output logic o_bc_invalidate,
    // Memory channel for the vector read
    output logic o_mem_req,
    output logic [31:0] o_mem_addr,
    output logic [2:0] o_mem_opt,
    output logic o_mem_data,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata
);
    // ========================================================
    // State and registers
    typedef enum logic [2:0] {
        ST_IDLE, ST_HALT_EXEC, ST_HALT_FETCH, ST_DRAIN, ST_SAVE,
        ST_VEC_REQ, ST_LAUNCH
    } trs_state_e;
    trs_state_e state;          // Sequencer state
    trs_state_e next_state;     // Following state
    logic [31:0] cfg;           // Configuration
    logic [31:0] vbase;         // Vector base
    logic [31:0] cps;           // Current status
    logic [31:0] ops;           // Old status
    logic [31:0] haddr;         // Handler address
    logic hrom;                 // Handler in ROM
    logic [7:0] vec;            // Latched vector number
    logic vtm;                  // Latched table mode

    // ========================================================
    // Address forming
    logic [31:0] table_addr;    // Vector entry address
    logic [31:0] block_addr;    // Block handler address
    logic [31:0] vec_target;    // Handler from vector word
    logic vec_rom;              // ROM bit of vector word

    trs_addr u_addr (
        .i_base(vbase),
        .i_vec(vec),
        .i_vec_word(i_mem_rdata),
        .o_table_addr(table_addr),
        .o_block_addr(block_addr),
        .o_vec_target(vec_target),
        .o_vec_rom(vec_rom)
    );

    // ========================================================
    // APB decode
    wire apb_setup = i_psel && !i_penable;         // Setup cycle
    wire apb_done = i_psel && i_penable && o_pready; // Completing edge
    wire apb_wr = apb_done && i_pwrite;            // Write takes effect
    wire sel_cfg = i_paddr == trs_pkg::OFF_CFG;
    wire sel_vbase = i_paddr == trs_pkg::OFF_VBASE;
    wire sel_cps = i_paddr == trs_pkg::OFF_CPS;
    wire sel_ops = i_paddr == trs_pkg::OFF_OPS;
    wire sel_stat = i_paddr == trs_pkg::OFF_STAT;
    wire sel_haddr = i_paddr == trs_pkg::OFF_HADDR;
    wire mapped = sel_cfg || sel_vbase || sel_cps || sel_ops ||
        sel_stat || sel_haddr;
    // Status word: busy, mode of last entry, last vector
    wire [31:0] stat_word = (32'(vec) << trs_pkg::STAT_VEC_LO) |
        (32'(vtm) << trs_pkg::STAT_VTM_BIT) |
        (32'(state != ST_IDLE) << trs_pkg::STAT_BUSY_BIT);
    wire [31:0] rd_mux = sel_cfg ? cfg :
        sel_vbase ? vbase :
        sel_cps ? cps :
        sel_ops ? ops :
        sel_stat ? stat_word :
        sel_haddr ? haddr : 32'h0000_0000;

    // ========================================================
    // Sequencer decode
    wire take_trap = state == ST_IDLE && i_trap_req;
    wire take_ret = state == ST_IDLE && !i_trap_req && i_ret_req;
    wire drain_done = state == ST_DRAIN && !i_ls_busy; // RULE_03
    wire vec_done = state == ST_VEC_REQ && i_mem_ack;
    // Entry status: affected bits forced, freeze set
    wire [31:0] entry_cps = (cps & ~ENTRY_MASK) |
        (ENTRY_SET & ENTRY_MASK) |
        (32'h0000_0001 << trs_pkg::CPS_FZ_BIT); // RULE_23

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (i_trap_req) begin
                    next_state = ST_HALT_EXEC;
                end
            end
            ST_HALT_EXEC: begin
                next_state = ST_HALT_FETCH; // RULE_02
            end
            ST_HALT_FETCH: begin
                next_state = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (drain_done) begin
                    next_state = ST_SAVE;
                end
            end
            ST_SAVE: begin
                // Table mode reads memory, block mode does not
                next_state = vtm ? ST_VEC_REQ : ST_LAUNCH; // RULE_07 RULE_09
            end
            ST_VEC_REQ: begin
                if (i_mem_ack) begin
                    next_state = ST_LAUNCH;
                end
            end
            ST_LAUNCH: begin
                next_state = ST_IDLE; // RULE_12
            end
        endcase
    end

    // ========================================================
    // State register
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Latch vector number and mode when the trap is taken
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            vec <= 8'h00;
            vtm <= 1'b0;
        end else if (take_trap) begin
            vec <= i_trap_vec; // RULE_19
            vtm <= cfg[trs_pkg::CFG_VTM_BIT];
        end
    end

    // Configuration and base, software only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cfg <= trs_pkg::CFG_RST;
            vbase <= trs_pkg::VBASE_RST;
        end else if (apb_wr && sel_cfg) begin
            cfg <= i_pwdata;
        end else if (apb_wr && sel_vbase) begin
            vbase <= i_pwdata;
        end
    end

    // Status pair; hardware entry wins over software write.
    // Of the writable registers only the status pair changes on entry, nothing else saved.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cps <= trs_pkg::CPS_RST;
            ops <= trs_pkg::CPS_RST;
        end else if (state == ST_SAVE) begin
            ops <= cps; // RULE_05 RULE_13
            cps <= entry_cps; // RULE_05
        end else if (state == ST_LAUNCH) begin
            cps[trs_pkg::CPS_RE_BIT] <= hrom; // RULE_10 RULE_11
        end else if (apb_wr && sel_cps) begin
            cps <= i_pwdata;
        end else if (apb_wr && sel_ops) begin
            ops <= i_pwdata;
        end
    end

    // Handler address and ROM select
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            haddr <= 32'h0000_0000;
            hrom <= 1'b0;
        end else if (vec_done) begin
            haddr <= vec_target; // RULE_07
            hrom <= vec_rom; // RULE_10
        end else if (state == ST_SAVE && !vtm) begin
            haddr <= block_addr; // RULE_09
            hrom <= cfg[trs_pkg::CFG_RV_BIT]; // RULE_11
        end
    end

    // ========================================================
    // Core control outputs
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_exec_hold <= 1'b0;
            o_fetch_hold <= 1'b0;
            o_lsm_cancel <= 1'b0;
            o_fetch_start <= 1'b0;
            o_fetch_addr <= 32'h0000_0000;
            o_fetch_rom <= 1'b0;
            o_resume <= 1'b0;
            o_bc_invalidate <= 1'b0;
            o_freeze <= 1'b0;
        end else begin
            // Execution held from the first entry step
            o_exec_hold <= next_state != ST_IDLE; // RULE_01
            o_fetch_hold <= next_state != ST_IDLE &&
                next_state != ST_HALT_EXEC; // RULE_02
            // Remaining multiple transfers dropped while draining
            o_lsm_cancel <= next_state == ST_DRAIN && i_lsm_active; // RULE_04
            o_fetch_start <= state == ST_LAUNCH; // RULE_12
            if (state == ST_LAUNCH) begin
                o_fetch_addr <= haddr;
                o_fetch_rom <= hrom;
            end
            o_resume <= take_ret; // RULE_16 RULE_17
            o_bc_invalidate <= take_ret && i_ret_inv; // RULE_16 RULE_17
            o_freeze <= state == ST_SAVE ? 1'b1 :
                cps[trs_pkg::CPS_FZ_BIT]; // RULE_06
        end
    end

    // Vector read on the memory channel
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_req <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_opt <= trs_pkg::OPT_WORD;
            o_mem_data <= 1'b0;
        end else begin
            o_mem_req <= next_state == ST_VEC_REQ; // RULE_07
            o_mem_data <= next_state == ST_VEC_REQ; // RULE_08
            o_mem_opt <= trs_pkg::OPT_WORD; // RULE_08
            if (state == ST_SAVE) begin
                o_mem_addr <= table_addr; // RULE_20
            end
        end
    end

    // ========================================================
    // APB answer: ready in the first access cycle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= apb_setup;
            o_pslverr <= apb_setup && !mapped;
            if (apb_setup && !i_pwrite) begin
                o_prdata <= rd_mux;
            end
        end
    end

    // ========================================================
    // Checks
    a_exec_first: assert property ( // RULE_01
        @(posedge i_mclk) disable iff (i_rst)
        $rose(o_exec_hold) |-> !o_fetch_hold ##1 o_fetch_hold)
        else $error("execution not stopped before fetch");
    a_fetch_stop: assert property ( // RULE_02
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_HALT_EXEC |=> o_fetch_hold && o_exec_hold)
        else $error("fetch not stopped after execution");
    a_drain_wait: assert property ( // RULE_03
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_DRAIN && i_ls_busy |=> state == ST_DRAIN)
        else $error("entry moved on with load or store busy");
    a_lsm_cancel: assert property ( // RULE_04
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_HALT_FETCH && i_lsm_active |=> o_lsm_cancel)
        else $error("multiple transfer not cancelled");
    a_old_status: assert property ( // RULE_05
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_SAVE |=> ops == $past(cps) &&
            cps[trs_pkg::CPS_FZ_BIT])
        else $error("status not saved on entry");
    a_freeze_out: assert property ( // RULE_06
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_SAVE |=> o_freeze [*2])
        else $error("freeze not shown after entry");
    a_vec_read: assert property ( // RULE_08
        @(posedge i_mclk) disable iff (i_rst)
        o_mem_req |-> o_mem_data && o_mem_opt == trs_pkg::OPT_WORD &&
            o_mem_addr[trs_pkg::VE_LO +: trs_pkg::VEC_W] == vec)
        else $error("vector read malformed");
    a_table_mode: assert property ( // RULE_07
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_SAVE && vtm |=> o_mem_req)
        else $error("no vector read in table mode");
    a_block_mode: assert property ( // RULE_09
        @(posedge i_mclk) disable iff (i_rst)
        state == ST_SAVE && !vtm |=> !o_mem_req ##1 o_fetch_start &&
            o_fetch_addr[trs_pkg::BLK_LO +: trs_pkg::VEC_W] == vec)
        else $error("block mode address wrong");
    a_rom_copy: assert property ( // RULE_10
        @(posedge i_mclk) disable iff (i_rst)
        o_fetch_start |-> cps[trs_pkg::CPS_RE_BIT] == o_fetch_rom)
        else $error("ROM select not copied");
    a_ret_inv: assert property ( // RULE_16
        @(posedge i_mclk) disable iff (i_rst)
        take_ret |=> o_resume && o_bc_invalidate == $past(i_ret_inv))
        else $error("return invalidate wrong");
    a_ret_plain: assert property ( // RULE_17
        @(posedge i_mclk) disable iff (i_rst)
        take_ret && !i_ret_inv |=> o_resume && !o_bc_invalidate)
        else $error("plain return touched branch cache");
endmodule

// *** dv/trs_vmem.sv ***
`timescale 1ns/100ps
// ============================================================
// Vector memory model on the far side of the channel
module trs_vmem (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Channel request
    input wire logic i_req,
    input wire logic [31:0] i_addr,
    input wire logic [3:0] i_lat,
    // Answer
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [3:0] cnt; // Wait cycles spent on this request
    logic [31:0] word; // Stored vector, ROM bit from address bit 2
    assign word = {~i_addr[31:1], i_addr[2]};
    // Answer after i_lat waits; data scrambles whenever not valid
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 4'h0;
            o_ack <= 1'b0;
            o_rdata <= 32'h0;
        end else if (i_req && !o_ack && cnt == i_lat) begin
            cnt <= 4'h0;
            o_ack <= 1'b1;
            o_rdata <= word;
        end else begin
            // Waiting or idle: no stale data left on the bus
            cnt <= (i_req && !o_ack) ? cnt + 4'h1 : 4'h0;
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// *** dv/trap_entry_return_sequencer_tb_top.sv ***
`timescale 1ns/100ps
// ============================================================
// Self-checking bench for the trap sequencer
module trap_entry_return_sequencer_tb_top;
    // ========================================================
    // Stimulus and observation signals
    logic i_mclk, i_rst, i_psel, i_penable, i_pwrite;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr;
    logic i_trap_req, i_ret_req, i_ret_inv, i_ls_busy, i_lsm_active;
    logic [7:0] i_trap_vec;
    logic o_exec_hold, o_fetch_hold, o_lsm_cancel, o_freeze;
    logic o_fetch_start, o_fetch_rom, o_resume, o_bc_invalidate;
    logic [31:0] o_fetch_addr, o_mem_addr, i_mem_rdata;
    logic o_mem_req, o_mem_data, i_mem_ack;
    logic [2:0] o_mem_opt;
    logic [3:0] mem_lat; // Memory answer delay
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0; // Cycles run so far
    localparam logic [31:0] VB = 32'h8765_4321; // Vector base used
    // ========================================================
    // Design and memory model
    trs_seq u_dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_trap_req(i_trap_req),
        .i_trap_vec(i_trap_vec), .i_ret_req(i_ret_req),
        .i_ret_inv(i_ret_inv), .i_ls_busy(i_ls_busy),
        .i_lsm_active(i_lsm_active), .o_exec_hold(o_exec_hold),
        .o_fetch_hold(o_fetch_hold), .o_lsm_cancel(o_lsm_cancel),
        .o_freeze(o_freeze), .o_fetch_start(o_fetch_start),
        .o_fetch_addr(o_fetch_addr), .o_fetch_rom(o_fetch_rom),
        .o_resume(o_resume), .o_bc_invalidate(o_bc_invalidate),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
        .o_mem_opt(o_mem_opt), .o_mem_data(o_mem_data),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata));
    trs_vmem u_mem (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_lat(mem_lat), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    // ========================================================
    // Clock and hang guard
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ========================================================
    // Compare and report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize();
        $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic err);
        int k;
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_mclk);
            k++;
        end while (o_pready !== 1'b1 && k < 20);
        // A slave that never answers counts as a mismatch
        if (o_pready !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] t=%0t pready=%h exp=%h", $time, o_pready, 1'b1);
        end
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_mclk);
    endtask
    // One trap entry with a load/store draining for six cycles
    task run_trap(input logic tbl, input logic rom_area,
                  input logic [7:0] vec, input logic [3:0] lat);
        logic [31:0] q, cps0, tab, w, exp_cps, exp_h;
        logic e, rom, seen_req, seen_cancel;
        int k, t_ex, t_fe, t_sv, t_st;
        cps0 = {24'h1, vec}; // Handler-in-ROM set, freeze clear
        tab = {VB[31:10], vec, VB[1:0]};
        w = {~tab[31:1], tab[2]};
        rom = tbl ? w[trs_pkg::VEC_ROM_BIT] : rom_area;
        exp_h = tbl ? (w & trs_pkg::WORD_ALIGN) : {VB[31:16], vec, VB[7:0]};
        apb(1'b1, trs_pkg::OFF_CFG, {30'h0, rom_area, tbl}, q, e);
        apb(1'b1, trs_pkg::OFF_CPS, cps0, q, e);
        t_ex = -1; t_fe = -1; t_sv = -1; t_st = -1;
        seen_req = 1'b0;
        seen_cancel = 1'b0;
        mem_lat <= lat;
        i_trap_req <= 1'b1;
        i_trap_vec <= vec;
        i_ls_busy <= 1'b1;
        i_lsm_active <= 1'b1;
        for (k = 0; k < 60 && t_st < 0; k++) begin
            @(posedge i_mclk);
            if (k == 0) i_trap_req <= 1'b0;
            if (k == 5) begin
                i_ls_busy <= 1'b0;
                i_lsm_active <= 1'b0;
            end
            if (o_exec_hold === 1'b1 && t_ex < 0) t_ex = k;
            if (o_fetch_hold === 1'b1 && t_fe < 0) t_fe = k;
            if (o_freeze === 1'b1 && t_sv < 0) t_sv = k;
            if (o_lsm_cancel === 1'b1) seen_cancel = 1'b1;
            if (o_mem_req === 1'b1) begin
                seen_req = 1'b1;
                chk(o_mem_addr, tab);
                chk({o_mem_data, o_mem_opt}, {1'b1, trs_pkg::OPT_WORD});
            end
            if (o_fetch_start === 1'b1) begin
                t_st = k;
                if (tbl) chk(o_fetch_addr, w & trs_pkg::WORD_ALIGN);
                else chk(o_fetch_addr, {VB[31:16], vec, VB[7:0]});
                chk(o_fetch_rom, rom);
                chk({o_exec_hold, o_fetch_hold}, 2'h0);
            end
        end
        chk(t_ex, 1);
        chk(t_fe, 2);
        chk(t_sv > 5, 1);
        chk(seen_cancel, 1'b1);
        chk(t_st > t_sv, 1);
        chk(seen_req, tbl);
        exp_cps = (cps0 & ~trs_pkg::CPS_ENTRY_MASK)
                  | (trs_pkg::CPS_ENTRY_SET & trs_pkg::CPS_ENTRY_MASK);
        exp_cps[trs_pkg::CPS_FZ_BIT] = 1'b1;
        exp_cps[trs_pkg::CPS_RE_BIT] = rom;
        @(posedge i_mclk);
        apb(1'b0, trs_pkg::OFF_OPS, 32'h0, q, e);
        chk(q, cps0);
        apb(1'b0, trs_pkg::OFF_CPS, 32'h0, q, e);
        chk(q, exp_cps);
        chk(o_freeze, 1'b1);
        // Handler address and last entry record as software sees them
        apb(1'b0, trs_pkg::OFF_HADDR, 32'h0, q, e);
        chk(q, exp_h);
        apb(1'b0, trs_pkg::OFF_STAT, 32'h0, q, e);
        chk(q, (32'(vec) << trs_pkg::STAT_VEC_LO) |
            (32'(tbl) << trs_pkg::STAT_VTM_BIT));
        apb(1'b1, trs_pkg::OFF_CPS, 32'h0, q, e);
        // Freeze output follows the cleared status one cycle on
        @(posedge i_mclk);
        chk(o_freeze, 1'b0);
        $display("trap test done vec=%h", vec);
    endtask
    // One return, with or without branch cache invalidation
    task run_ret(input logic inv);
        logic [31:0] q;
        logic e;
        // Software freezes the registers before returning
        apb(1'b1, trs_pkg::OFF_CPS, 32'h1 << trs_pkg::CPS_FZ_BIT, q, e);
        @(posedge i_mclk);
        chk(o_freeze, 1'b1);
        i_ret_req <= 1'b1;
        i_ret_inv <= inv;
        @(posedge i_mclk);
        i_ret_req <= 1'b0;
        @(posedge i_mclk);
        chk({o_resume, o_bc_invalidate}, {1'b1, inv});
        @(posedge i_mclk);
        chk({o_resume, o_bc_invalidate}, 2'h0);
        $display("return test done inv=%0d", inv);
    endtask
    // ========================================================
    // Main sequence
    initial begin
        logic [31:0] q;
        logic e;
        i_rst = 1'b1;
        i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
        i_paddr = 8'h00; i_pwdata = 32'h0; mem_lat = 4'h0;
        i_trap_req = 1'b0; i_trap_vec = 8'h00; i_ret_req = 1'b0;
        i_ret_inv = 1'b0; i_ls_busy = 1'b0; i_lsm_active = 1'b0;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        // Reset values and an unmapped place
        apb(1'b0, trs_pkg::OFF_CFG, 32'h0, q, e);
        chk(q, trs_pkg::CFG_RST);
        apb(1'b0, trs_pkg::OFF_CPS, 32'h0, q, e);
        chk(q, trs_pkg::CPS_RST);
        apb(1'b0, 8'h18, 32'h0, q, e);
        chk({e, q}, {1'b1, 32'h0});
        apb(1'b1, trs_pkg::OFF_VBASE, VB, q, e);
        $display("register test done");
        // Table mode at both vector ends, slow and prompt memory
        run_trap(1'b1, 1'b0, 8'h00, 4'h3);
        run_trap(1'b1, 1'b1, 8'hFF, 4'h0);
        run_trap(1'b1, 1'b0, 8'h5B, 4'h7);
        // Block mode, both ROM area settings
        run_trap(1'b0, 1'b0, 8'hA5, 4'h0);
        run_trap(1'b0, 1'b1, 8'hFF, 4'h0);
        run_ret(1'b0);
        run_ret(1'b1);
        summarize();
    end
endmodule
